// *** rtl/spisd_map.svh ***
// Register offsets, field positions, reset values and rate counts of the serial port.
// Assumes inclusion by bare name from the register module.
`ifndef SPISD_MAP_SVH
`define SPISD_MAP_SVH

// Register offsets
`define SPISD_OFS_DATA 8'h21
`define SPISD_OFS_CTRL 8'h22
`define SPISD_OFS_CSR 8'h23
`define SPISD_OFS_EVT_STS 8'h24
`define SPISD_OFS_EVT_CLR 8'h25
`define SPISD_OFS_EVT_EN 8'h26

// Control register fields
`define SPISD_CTRL_IRQ_EN 7
`define SPISD_CTRL_PORT_EN 6
`define SPISD_CTRL_SPR2 5
`define SPISD_CTRL_MASTER 4
`define SPISD_CTRL_CPOL 3
`define SPISD_CTRL_CPHA 2
`define SPISD_CTRL_SPR1 1
`define SPISD_CTRL_SPR0 0

// Control/status register fields
`define SPISD_CSR_DONE 7
`define SPISD_CSR_WRITE_COLLISION_FLAG 6
`define SPISD_CSR_OVR 5
`define SPISD_CSR_MODE_FAULT_FLAG 4
`define SPISD_CSR_RSVD 3
`define SPISD_CSR_SOD 2
`define SPISD_CSR_SSM 1
`define SPISD_CSR_SSI 0

// Event status bits
`define SPISD_EVT_DONE 0
`define SPISD_EVT_WRITE_COLLISION_FLAG 1
`define SPISD_EVT_OVR 2
`define SPISD_EVT_MODE_FAULT_FLAG 3

// Reset values
`define SPISD_RST_CTRL 8'h00
`define SPISD_RST_CSR 8'h00
`define SPISD_RST_EVT_EN 4'hD

// Serial clock half periods in clk cycles, by {spr2,spr1,spr0}
`define SPISD_HALF_DIV4 6'h02
`define SPISD_HALF_DIV8 6'h04
`define SPISD_HALF_DIV16 6'h08
`define SPISD_HALF_DIV32 6'h10
`define SPISD_HALF_DIV64 6'h20
`define SPISD_HALF_DIV128 6'h40

// Index of the last of the 16 clock edges in one byte
`define SPISD_LAST_EDGE 4'hF

`endif

// *** rtl/spisd_pkg.sv ***
// Types of the serial port block.
// Assumes spisd_map.svh for the constants.
package spisd_pkg;

    typedef enum logic {
        SPISD_IDLE = 1'b0,
        SPISD_RUN = 1'b1
    } spisd_phase_t;

    typedef struct packed {
        logic [3:0] q1;
        logic [3:0] q2;
    } spisd_sync_st_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic output_disable;
        logic select_by_software;
        logic internal_select_level;
        logic done_flag;
        logic write_collision_flag_flag;
        logic ovr_flag;
        logic mode_fault_flag_flag;
        logic done_arm;
        logic write_collision_flag_arm;
        logic mode_fault_flag_arm;
        logic [7:0] rxbuf;
        logic [3:0] evt;
        logic [3:0] evt_en;
        logic irq;
        logic [7:0] rdata;
        logic sck_oe;
        logic mosi_oe;
        logic miso_oe;
        spisd_phase_t phase;
        logic [3:0] edge_cnt;
        logic [5:0] div_cnt;
        logic [7:0] shreg;
        logic sck;
        logic sdo;
        logic sck_prev;
    } spisd_st_t;

endpackage : spisd_pkg

// *** rtl/spisd_sync.sv ***
// Two-stage synchroniser for the four serial pins.
// Assumes asynchronous pin levels; only the second stage is read outside.
`timescale 1ns/100ps
module spisd_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_sync
);
    spisd_pkg::spisd_sync_st_t s_ff;
    spisd_pkg::spisd_sync_st_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.q1 = pin_in;
        nxt_s.q2 = s_ff.q1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pin_sync = s_ff.q2;
endmodule : spisd_sync

// *** rtl/spisd_regs.sv ***
// Serial peripheral port: data, control and status registers with the byte shifter.
// Assumes one-cycle register strobes on clk and asynchronous serial pins.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "spisd_map.svh"
module spisd_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial clock
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    // Master out data
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    // Master in data
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    // Slave select
    input wire logic ss_n_i,
    // Interrupt
    output logic irq
);
    spisd_pkg::spisd_st_t s_ff;
    spisd_pkg::spisd_st_t nxt_s;
    logic [3:0] pin_sync;

    // Half period of the master serial clock
    function automatic logic [5:0] half_period(input logic [2:0] sel);
        logic [5:0] h;
        h = `SPISD_HALF_DIV128;
        unique case (sel)
            3'h4: h = `SPISD_HALF_DIV4;
            3'h0: h = `SPISD_HALF_DIV8;
            3'h1: h = `SPISD_HALF_DIV16;
            3'h6: h = `SPISD_HALF_DIV32;
            3'h2: h = `SPISD_HALF_DIV64;
            3'h3: h = `SPISD_HALF_DIV128;
            3'h5: h = `SPISD_HALF_DIV128;
            3'h7: h = `SPISD_HALF_DIV128;
        endcase
        return h;
    endfunction : half_period

    spisd_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in({ss_n_i, miso_i, mosi_i, sck_i}),
        .pin_sync(pin_sync)
    );

    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;
    logic data_wr;
    logic data_rd;
    logic ctrl_wr;
    logic csr_wr;
    logic csr_rd;
    logic clr_wr;
    logic en_wr;
    logic port_enable_bit;
    logic master_select_bit;
    logic int_ss;
    logic busy;
    logic wr_block;
    logic load;
    logic collide;
    logic mode_fault;
    logic edge_go;
    logic done;
    logic done_clr;
    logic ovr_set;
    logic [5:0] half;
    logic sdi;

    assign sck_s = pin_sync[0];
    assign mosi_s = pin_sync[1];
    assign miso_s = pin_sync[2];
    assign ss_s = pin_sync[3];

    always_comb begin
        nxt_s = s_ff;
        data_wr = reg_wr && (reg_addr == `SPISD_OFS_DATA);
        data_rd = reg_rd && (reg_addr == `SPISD_OFS_DATA);
        ctrl_wr = reg_wr && (reg_addr == `SPISD_OFS_CTRL);
        csr_wr = reg_wr && (reg_addr == `SPISD_OFS_CSR);
        csr_rd = reg_rd && (reg_addr == `SPISD_OFS_CSR);
        clr_wr = reg_wr && (reg_addr == `SPISD_OFS_EVT_CLR);
        en_wr = reg_wr && (reg_addr == `SPISD_OFS_EVT_EN);
        port_enable_bit = s_ff.ctrl[`SPISD_CTRL_PORT_EN];
        master_select_bit = s_ff.ctrl[`SPISD_CTRL_MASTER];
        half = half_period({s_ff.ctrl[`SPISD_CTRL_SPR2], s_ff.ctrl[`SPISD_CTRL_SPR1],
                            s_ff.ctrl[`SPISD_CTRL_SPR0]});
        // Internal select from pin or software bit
        int_ss = s_ff.select_by_software ? s_ff.internal_select_level : ss_s;
        sdi = master_select_bit ? miso_s : mosi_s;
        busy = (s_ff.phase == spisd_pkg::SPISD_RUN);
        wr_block = s_ff.done_flag && !s_ff.done_arm;
        collide = data_wr && busy;
        load = data_wr && !wr_block && !busy && port_enable_bit;
        mode_fault = master_select_bit && port_enable_bit && !int_ss;
        edge_go = 1'b0;
        done = 1'b0;

        // Byte shifter
        nxt_s.sck_prev = sck_s;
        if (!port_enable_bit) begin
            nxt_s.phase = spisd_pkg::SPISD_IDLE;
            nxt_s.edge_cnt = '0;
            nxt_s.div_cnt = '0;
            nxt_s.sck = s_ff.ctrl[`SPISD_CTRL_CPOL];
        end else if (master_select_bit) begin
            if (busy) begin
                if (s_ff.div_cnt == half - 6'h01) begin
                    nxt_s.div_cnt = '0;
                    nxt_s.sck = !s_ff.sck;
                    edge_go = 1'b1;
                end else begin
                    nxt_s.div_cnt = s_ff.div_cnt + 6'h01;
                end
            end else begin
                nxt_s.sck = s_ff.ctrl[`SPISD_CTRL_CPOL];
            end
        end else if (int_ss) begin
            nxt_s.phase = spisd_pkg::SPISD_IDLE;
            nxt_s.edge_cnt = '0;
        end else if (sck_s != s_ff.sck_prev) begin
            edge_go = 1'b1;
        end
        if (load) begin
            nxt_s.shreg = reg_wdata;
            nxt_s.edge_cnt = '0;
            nxt_s.div_cnt = '0;
            if (!s_ff.ctrl[`SPISD_CTRL_CPHA]) begin
                nxt_s.sdo = reg_wdata[7];
            end
            if (master_select_bit) begin
                nxt_s.phase = spisd_pkg::SPISD_RUN;
            end
        end
        if (edge_go) begin
            if (s_ff.edge_cnt[0] == s_ff.ctrl[`SPISD_CTRL_CPHA]) begin
                nxt_s.shreg = {s_ff.shreg[6:0], sdi};
            end else begin
                nxt_s.sdo = s_ff.shreg[7];
            end
            nxt_s.phase = spisd_pkg::SPISD_RUN;
            if (s_ff.edge_cnt == `SPISD_LAST_EDGE) begin
                nxt_s.edge_cnt = '0;
                nxt_s.phase = spisd_pkg::SPISD_IDLE;
                done = 1'b1;
            end else begin
                nxt_s.edge_cnt = s_ff.edge_cnt + 4'h1;
            end
        end

        // Transfer done flag, set wins over clear
        done_clr = s_ff.done_arm && (data_rd || data_wr);
        ovr_set = done && s_ff.done_flag && !done_clr;
        if (done) begin
            nxt_s.done_flag = 1'b1;
            nxt_s.done_arm = 1'b0;
        end else if (done_clr) begin
            nxt_s.done_flag = 1'b0;
            nxt_s.done_arm = 1'b0;
        end else if (csr_rd && s_ff.done_flag) begin
            nxt_s.done_arm = 1'b1;
        end
        if (done && !ovr_set) begin
            nxt_s.rxbuf = nxt_s.shreg;
        end

        // Overrun flag
        if (ovr_set) begin
            nxt_s.ovr_flag = 1'b1;
        end else if (csr_rd) begin
            nxt_s.ovr_flag = 1'b0;
        end

        // Write collision flag
        if (collide) begin
            nxt_s.write_collision_flag_flag = 1'b1;
            nxt_s.write_collision_flag_arm = 1'b0;
        end else if (s_ff.write_collision_flag_arm && (data_rd || data_wr)) begin
            nxt_s.write_collision_flag_flag = 1'b0;
            nxt_s.write_collision_flag_arm = 1'b0;
        end else if (csr_rd && s_ff.write_collision_flag_flag) begin
            nxt_s.write_collision_flag_arm = 1'b1;
        end

        // Control and control/status registers
        if (ctrl_wr) begin
            nxt_s.ctrl = reg_wdata;
        end
        if (csr_wr) begin
            nxt_s.output_disable = reg_wdata[`SPISD_CSR_SOD];
            nxt_s.select_by_software = reg_wdata[`SPISD_CSR_SSM];
            nxt_s.internal_select_level = reg_wdata[`SPISD_CSR_SSI];
        end

        // Mode fault flag
        if (mode_fault) begin
            nxt_s.mode_fault_flag_flag = 1'b1;
            nxt_s.mode_fault_flag_arm = 1'b0;
            nxt_s.ctrl[`SPISD_CTRL_PORT_EN] = 1'b0;
            nxt_s.ctrl[`SPISD_CTRL_MASTER] = 1'b0;
        end else if (ctrl_wr && s_ff.mode_fault_flag_arm) begin
            nxt_s.mode_fault_flag_flag = 1'b0;
            nxt_s.mode_fault_flag_arm = 1'b0;
        end else if (csr_rd && s_ff.mode_fault_flag_flag) begin
            nxt_s.mode_fault_flag_arm = 1'b1;
        end

        // Sticky events, set wins over clear
        if (clr_wr) begin
            nxt_s.evt = s_ff.evt & ~reg_wdata[3:0];
        end
        if (en_wr) begin
            nxt_s.evt_en = reg_wdata[3:0];
        end
        if (done) begin
            nxt_s.evt[`SPISD_EVT_DONE] = 1'b1;
        end
        if (collide) begin
            nxt_s.evt[`SPISD_EVT_WRITE_COLLISION_FLAG] = 1'b1;
        end
        if (ovr_set) begin
            nxt_s.evt[`SPISD_EVT_OVR] = 1'b1;
        end
        if (mode_fault && !s_ff.mode_fault_flag_flag) begin
            nxt_s.evt[`SPISD_EVT_MODE_FAULT_FLAG] = 1'b1;
        end
        // Single shared interrupt line
        nxt_s.irq = s_ff.ctrl[`SPISD_CTRL_IRQ_EN] &&
                    (|(s_ff.evt & s_ff.evt_en));

        // Pin drivers
        nxt_s.sck_oe = port_enable_bit && master_select_bit;
        nxt_s.mosi_oe = port_enable_bit && master_select_bit && !s_ff.output_disable;
        nxt_s.miso_oe = port_enable_bit && !master_select_bit && !s_ff.output_disable && !int_ss;

        // Read data, valid one cycle after the strobe
        nxt_s.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `SPISD_OFS_DATA: nxt_s.rdata = s_ff.rxbuf;
                `SPISD_OFS_CTRL: nxt_s.rdata = s_ff.ctrl;
                `SPISD_OFS_CSR: nxt_s.rdata = {s_ff.done_flag, s_ff.write_collision_flag_flag,
                                               s_ff.ovr_flag, s_ff.mode_fault_flag_flag, 1'b0,
                                               s_ff.output_disable, s_ff.select_by_software, s_ff.internal_select_level};
                `SPISD_OFS_EVT_STS: nxt_s.rdata = {4'h0, s_ff.evt};
                `SPISD_OFS_EVT_EN: nxt_s.rdata = {4'h0, s_ff.evt_en};
                default: nxt_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
            s_ff.ctrl <= `SPISD_RST_CTRL;
            s_ff.evt_en <= `SPISD_RST_EVT_EN;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign reg_rdata = s_ff.rdata;
    assign sck_o = s_ff.sck;
    assign sck_oe = s_ff.sck_oe;
    assign mosi_o = s_ff.sdo;
    assign mosi_oe = s_ff.mosi_oe;
    assign miso_o = s_ff.sdo;
    assign miso_oe = s_ff.miso_oe;
    assign irq = s_ff.irq;
endmodule : spisd_regs

// *** testbench/spisd_regs_sva.sv ***
// Concurrent checks of the serial port register block.
// Assumes a bind to spisd_regs; sees only its ports.
`timescale 1ns/100ps
module spisd_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Serial pins
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_RD_IDLE_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED_ZERO: assert property ($past(reg_rd) && ($past(reg_addr) < 8'h21
        || $past(reg_addr) > 8'h26 || $past(reg_addr) == 8'h25) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CSR_RSVD: assert property ($past(reg_rd) && $past(reg_addr) == 8'h23
        |-> !reg_rdata[3])
        else $error("reserved status bit set");
    AST_OE_EXCL: assert property (!(mosi_oe && miso_oe))
        else $error("both data outputs driven");
    AST_MOSI_MASTER: assert property (mosi_oe |-> sck_oe)
        else $error("master out driven while not master");
    AST_MISO_SLAVE: assert property (miso_oe |-> !sck_oe)
        else $error("slave out driven while master");
    AST_IRQ_OFF: assert property (reg_wr && reg_addr == 8'h22 && !reg_wdata[7]
        ##1 !(reg_wr && reg_addr == 8'h22) |-> ##1 !irq)
        else $error("interrupt high with enable cleared");
    AST_SCK_HALF: assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o))
        else $error("serial clock half period below two cycles");

    cover property ($rose(irq));
    cover property ($fell(sck_oe));
    cover property (miso_oe);
    cover property (mosi_oe && $changed(sck_o));
endmodule : spisd_regs_chk

bind spisd_regs spisd_regs_chk u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .irq(irq));

// *** testbench/spisd_slave_model.sv ***
// Slave device on the far side of the master link.
// Assumes clock idle low and capture on the first edge.
`timescale 1ns/100ps
module spisd_slave_model (
    // Serial lines
    input wire logic sck,
    input wire logic sck_oe,
    input wire logic mosi,
    output logic miso,
    // Reply and captured bytes
    input wire logic [7:0] reply,
    output logic [7:0] captured
);
    logic [7:0] sh = 8'h00;
    logic [2:0] cnt = 3'h0;

    // Reply loaded once the bench has settled, before the first frame
    initial begin
        #1;
        sh = reply;
    end
    // Capture MSB first on rising edge
    always @(posedge sck) begin
        captured <= {captured[6:0], mosi};
        cnt <= cnt + 3'h1;
    end
    // Shift on falling edge, reload after a byte
    always @(negedge sck) begin
        sh <= (cnt == 3'h0) ? reply : {sh[6:0], 1'b0};
    end
    // Released line shows inverse of last bit
    assign miso = sck_oe ? sh[7] : ~sh[7];
endmodule : spisd_slave_model

// *** testbench/spisd_regs_tb.sv ***
// Self-checking bench of the serial port register block.
// Assumes spisd_regs, the slave model and the bound checker.
`timescale 1ns/100ps
module spisd_regs_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sck_i = 1'b0;
    logic mosi_i = 1'b0;
    logic miso_i;
    logic ss_n_i = 1'b1;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq;
    logic [7:0] reply = 8'h3C;
    logic [7:0] cap;
    int errors = 0;
    int n_checks = 0;

    always #12.5 clk = ~clk;

    spisd_regs dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_i(sck_i),
        .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
        .ss_n_i(ss_n_i), .irq(irq));

    spisd_slave_model u_slave (.sck(sck_o), .sck_oe(sck_oe), .mosi(mosi_o),
        .miso(miso_i), .reply(reply), .captured(cap));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : rdc

    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            mosi_i <= b[i];
            repeat (4) @(posedge clk);
            sck_i <= 1'b1;
            repeat (4) @(posedge clk);
            sck_i <= 1'b0;
        end
        mosi_i <= ~b[0];
        repeat (8) @(posedge clk);
    endtask : sbyte

    task automatic wirq;
        for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clk);
        check({7'h00, irq}, 8'h01);
    endtask : wirq

    task automatic print_verdict;
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rdc(8'h23, 8'h00);
        rdc(8'h22, 8'h00);
        rdc(8'h26, 8'h0D);
        rdc(8'h30, 8'h00);
        rdc(8'h25, 8'h00);
        wr(8'h23, 8'hF7);
        rdc(8'h23, 8'h07);
        // Slave, selected by software, pin high
        wr(8'h22, 8'h40);
        wr(8'h23, 8'h02);
        rdc(8'h23, 8'h02);
        check({7'h00, miso_oe}, 8'h01);
        // Slave load puts the first reply bit on the output at once
        wr(8'h21, 8'h96);
        #1 check({7'h00, miso_o}, 8'h01);
        sbyte(8'h5A);
        sbyte(8'hC3);
        check({7'h00, irq}, 8'h00);
        rdc(8'h23, 8'hA2);
        rdc(8'h23, 8'h82);
        rdc(8'h21, 8'h5A);
        rdc(8'h23, 8'h02);
        wr(8'h23, 8'h06);
        repeat (3) @(posedge clk);
        check({7'h00, miso_oe}, 8'h00);
        wr(8'h23, 8'h03);
        sbyte(8'hFF);
        rdc(8'h23, 8'h03);
        // Master transfers
        wr(8'h23, 8'h00);
        wr(8'h25, 8'h0F);
        wr(8'h22, 8'hD1);
        wr(8'h21, 8'hA5);
        wr(8'h21, 8'h00);
        check({7'h00, mosi_oe}, 8'h01);
        wirq();
        rdc(8'h23, 8'hC0);
        rdc(8'h24, 8'h03);
        check(cap, 8'hA5);
        rdc(8'h21, 8'h3C);
        rdc(8'h23, 8'h00);
        wr(8'h25, 8'h0F);
        wr(8'h21, 8'h81);
        repeat (3) @(posedge clk);
        check({7'h00, irq}, 8'h00);
        wirq();
        wr(8'h21, 8'h7E);
        repeat (200) @(posedge clk);
        check(cap, 8'h81);
        rdc(8'h23, 8'h80);
        rdc(8'h21, 8'h3C);
        // Mode fault, masked then enabled
        wr(8'h25, 8'h0F);
        wr(8'h26, 8'h00);
        ss_n_i <= 1'b0;
        repeat (8) @(posedge clk);
        check({7'h00, irq}, 8'h00);
        rdc(8'h22, 8'h81);
        rdc(8'h24, 8'h08);
        wr(8'h26, 8'h08);
        ss_n_i <= 1'b1;
        repeat (3) @(posedge clk);
        check({7'h00, irq}, 8'h01);
        rdc(8'h23, 8'h10);
        wr(8'h22, 8'h00);
        rdc(8'h23, 8'h00);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : spisd_regs_tb
